// ===== src/dtsp_pkg.sv
package dtsp_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register addresses on the internal register port.
	localparam logic [7:0] ADDR_POWER_CTRL  = 8'h87;
	localparam logic [7:0] ADDR_TIMER_CTRL  = 8'h88;
	localparam logic [7:0] ADDR_TIMER_MODE  = 8'h89;
	localparam logic [7:0] ADDR_FIRST_LOW   = 8'h8a;
	localparam logic [7:0] ADDR_SECOND_LOW  = 8'h8b;
	localparam logic [7:0] ADDR_FIRST_HIGH  = 8'h8c;
	localparam logic [7:0] ADDR_SECOND_HIGH = 8'h8d;
	localparam logic [7:0] ADDR_SERIAL_CTRL = 8'h98;
	localparam logic [7:0] ADDR_SERIAL_BUF  = 8'h99;
	localparam logic [7:0] ADDR_PORT2_MODE  = 8'ha4;
	localparam logic [7:0] REG_RST          = 8'h00;

	// Bit positions inside the control registers.
	localparam int CTL_SECOND_OVF = 7;
	localparam int CTL_SECOND_RUN = 6;
	localparam int CTL_FIRST_OVF  = 5;
	localparam int CTL_FIRST_RUN  = 4;
	localparam int SC_MODE_HI     = 7;
	localparam int SC_MODE_LO     = 6;
	localparam int SC_MPQ         = 5;
	localparam int SC_RX_EN       = 4;
	localparam int SC_TX9         = 3;
	localparam int SC_RX9         = 2;
	localparam int SC_TX_DONE     = 1;
	localparam int SC_RX_DONE     = 0;
	localparam int PC_BAUD_DBL    = 7;
	localparam int PC_BIT7_SEL    = 6;
	localparam int PM_FIRST_TOG   = 0;
	localparam int PM_SECOND_TOG  = 1;

	// Operating modes of the timers and of the serial port.
	localparam logic [1:0] TM_13     = 2'h0;
	localparam logic [1:0] TM_16     = 2'h1;
	localparam logic [1:0] TM_RELOAD = 2'h2;
	localparam logic [1:0] TM_SPLIT  = 2'h3;
	localparam logic [1:0] SM_SHIFT  = 2'h0;
	localparam logic [1:0] SM_UART8  = 2'h1;
	localparam logic [1:0] SM_FIXED9 = 2'h2;
	localparam logic [1:0] SM_VAR9   = 2'h3;

	// Timing: a machine cycle is six clocks, a bit is sixteen sample ticks.
	localparam logic [2:0] MC_LAST        = 3'h5;
	localparam logic [2:0] SCLK_HIGH_FROM = 3'h3;
	localparam logic [3:0] BIT_MID        = 4'h7;
	localparam logic [3:0] BIT_LAST       = 4'hf;
	localparam logic [3:0] SHIFT_BITS     = 4'h8;
	localparam logic [3:0] FRAME_LEN_8    = 4'ha;
	localparam logic [3:0] FRAME_LEN_9    = 4'hb;
	localparam logic [7:0] BYTE_MAX       = 8'hff;
	localparam logic [4:0] LOW13_MAX      = 5'h1f;

	typedef struct packed {
		logic       gate;
		logic       ct;
		logic [1:0] mode;
	} dtsp_tmode_t;

	typedef enum logic [1:0] {RX_IDLE, RX_SHIFT, RX_ASYNC} dtsp_rx_st_t;

endpackage

// ===== src/dtsp_timer.sv
`timescale 1ns/100ps
module dtsp_timer (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [1:0] mode,
	input  wire logic       cnt_en,
	input  wire logic       hi_en,
	input  wire logic       wr_lo,
	input  wire logic       wr_hi,
	input  wire logic [7:0] wdata,
	output logic      [7:0] tl_q,
	output logic      [7:0] th_q,
	output logic            lo_ovf,
	output logic            hi_ovf
);

	////////////////////////////////////////////////////////////////////////////////
	// Rollover detection per mode, qualified by the count pulse.
	always_comb begin
		unique case (mode)
			dtsp_pkg::TM_13: lo_ovf = cnt_en && th_q == dtsp_pkg::BYTE_MAX
				&& tl_q[4:0] == dtsp_pkg::LOW13_MAX;
			dtsp_pkg::TM_16: lo_ovf = cnt_en && th_q == dtsp_pkg::BYTE_MAX
				&& tl_q == dtsp_pkg::BYTE_MAX;
			default: lo_ovf = cnt_en && tl_q == dtsp_pkg::BYTE_MAX;
		endcase
	end
	assign hi_ovf = hi_en && mode == dtsp_pkg::TM_SPLIT && th_q == dtsp_pkg::BYTE_MAX;

	// Low byte; a software write wins over a count in the same cycle.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tl_q <= dtsp_pkg::REG_RST;
		end else if (wr_lo) begin
			tl_q <= wdata;
		end else if (cnt_en) begin
			unique case (mode)
				dtsp_pkg::TM_13: tl_q[4:0] <= tl_q[4:0] + 5'h01;
				dtsp_pkg::TM_RELOAD: tl_q <= (tl_q == dtsp_pkg::BYTE_MAX) ? th_q
					: tl_q + 8'h01;
				default: tl_q <= tl_q + 8'h01;
			endcase
		end
	end

	// High byte; in split mode it runs on its own enable.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			th_q <= dtsp_pkg::REG_RST;
		end else if (wr_hi) begin
			th_q <= wdata;
		end else if (mode == dtsp_pkg::TM_SPLIT) begin
			if (hi_en) begin
				th_q <= th_q + 8'h01;
			end
		end else if (cnt_en) begin
			if (mode == dtsp_pkg::TM_13 && tl_q[4:0] == dtsp_pkg::LOW13_MAX) begin
				th_q <= th_q + 8'h01;
			end else if (mode == dtsp_pkg::TM_16 && tl_q == dtsp_pkg::BYTE_MAX) begin
				th_q <= th_q + 8'h01;
			end
		end
	end

endmodule // dtsp_timer

// ===== src/dtsp_rx.sv
`timescale 1ns/100ps
module dtsp_rx (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [1:0] smode,
	input  wire logic       rx_en,
	input  wire logic       shift_go,
	input  wire logic       mc_tick,
	input  wire logic       tick16,
	input  wire logic       rxd_s,
	output logic            shift_busy,
	output logic            done_q,
	output logic      [8:0] sh_q,
	output logic            stop_q
);

	dtsp_pkg::dtsp_rx_st_t st_q;
	logic [3:0]            ph_q;
	logic [3:0]            bit_q;
	logic [3:0]            stop_idx;

	////////////////////////////////////////////////////////////////////////////////
	// Index of the stop bit within the frame, start bit being zero.
	assign stop_idx   = (smode == dtsp_pkg::SM_UART8) ? dtsp_pkg::FRAME_LEN_8 - 4'h1
		: dtsp_pkg::FRAME_LEN_9 - 4'h1;
	assign shift_busy = st_q == dtsp_pkg::RX_SHIFT;

	// Bits are sampled in the middle of their cell; a start bit that is high
	// again at mid-cell was a glitch and the receiver returns to idle.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q   <= dtsp_pkg::RX_IDLE;
			ph_q   <= 4'h0;
			bit_q  <= 4'h0;
			done_q <= 1'b0;
			sh_q   <= 9'h000;
			stop_q <= 1'b1;
		end else begin
			done_q <= 1'b0;
			unique case (st_q)
				dtsp_pkg::RX_IDLE: begin
					ph_q  <= 4'h0;
					bit_q <= 4'h0;
					if (shift_go) begin
						st_q <= dtsp_pkg::RX_SHIFT;
					end else if (smode != dtsp_pkg::SM_SHIFT && rx_en && tick16 && !rxd_s) begin
						st_q <= dtsp_pkg::RX_ASYNC;
					end
				end
				dtsp_pkg::RX_SHIFT: if (mc_tick) begin
					sh_q[7:0] <= {rxd_s, sh_q[7:1]};
					bit_q     <= bit_q + 4'h1;
					if (bit_q == dtsp_pkg::SHIFT_BITS - 4'h1) begin
						done_q <= 1'b1;
						st_q   <= dtsp_pkg::RX_IDLE;
					end
				end
				dtsp_pkg::RX_ASYNC: if (tick16) begin
					ph_q <= ph_q + 4'h1;
					if (ph_q == dtsp_pkg::BIT_MID) begin
						bit_q <= bit_q + 4'h1;
						if (bit_q == 4'h0 && rxd_s) begin
							st_q <= dtsp_pkg::RX_IDLE;
						end else if (bit_q == stop_idx) begin
							stop_q <= rxd_s;
							done_q <= 1'b1;
							st_q   <= dtsp_pkg::RX_IDLE;
						end else if (bit_q != 4'h0) begin
							sh_q[bit_q - 4'h1] <= rxd_s;
						end
					end
				end
			endcase
		end
	end

endmodule // dtsp_rx

// ===== src/dtsp_top.sv
`timescale 1ns/100ps
// Function
// - 13-bit mode: high byte plus five low bits.
// - Rollover sets the timer overflow flag.
// - Count only if run and gate allows.
// - Setting run bit keeps counter bytes.
// - Gate bits: mode bit 7 and bit 3.
// - 16-bit mode uses all sixteen bits.
// - Auto-reload low byte from high byte.
// - Second timer in split mode halts.
// - Split: high byte counts cycles, second flag.
// - Toggle count pin on overflow, starts high.
// - Full duplex, overrun loses older byte.
// - Buffer write transmits, read returns receive.
// - Shift mode: data on rxd, clock txd.
// - Mode 1: ten bits, stop to ninth.
// - Modes 2/3: eleven bits with ninth bit.
// - Mode 2 rate: clock/32 or clock/16.
// - Mode 3 equals mode 2, timer rate.
// - Transmit on write; receive start conditions.
// - Mode select bits decode four modes.
// - Control bit 7: mode or framing error.
// - Missing stop sets sticky framing error.
// - Receive done cleared by software only.
// - Timer counts per six clocks, counter edges.
// - Mode register holds function and mode.
module dtsp_top (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic [7:0] sfr_addr,
	input  wire logic [7:0] sfr_wdata,
	input  wire logic       sfr_wr,
	input  wire logic       sfr_rd,
	output logic      [7:0] sfr_rdata,
	input  wire logic [1:0] count_pin_in,
	output logic      [1:0] count_pin_out,
	output logic      [1:0] count_pin_oe,
	input  wire logic [1:0] gating_input_pin,
	input  wire logic       rxd_in,
	output logic            rxd_out,
	output logic            rxd_oe,
	output logic            txd
);

	dtsp_pkg::dtsp_tmode_t tmode_q [2];
	logic [4:0] meta_q, sync_q;
	logic [2:0] pre_q;
	logic       mc_tick, sclk, hi_ovf0, half_q, brg_src, tick16;
	logic [1:0] run_q, ovf_q, tog_en_q, tog_q, prev_q, cnt_en, set_ovf, lo_ovf;
	logic [7:0] tl0, th0, tl1, th1, rx_buf_q;
	logic       baud_dbl_q, bit7_sel_q, mode_hi_q, mode_lo_q, mpq_q, rx_en_q;
	logic       tx9_q, rx9_q, tx_done_q, rx_done_q, frame_err_q;
	logic [1:0] smode;
	logic       tx_busy_q, tx_step, tx_fin, rx_fin, rx_shift, rx_stop, shift_go;
	logic [10:0] tx_sh_q;
	logic [3:0] tx_bit_q, tx_ph_q, tx_len;
	logic [8:0] rx_sh;

	// A write strobe to one register address.
	function automatic logic wr_to(input logic [7:0] a);
		return sfr_wr && sfr_addr == a;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pins from outside pass two flip-flops; only the second stage is read.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_q <= 5'h1f;
			sync_q <= 5'h1f;
		end else begin
			meta_q <= {rxd_in, gating_input_pin, count_pin_in};
			sync_q <= meta_q;
		end
	end

	// Machine cycle prescaler: one tick every six clocks.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pre_q <= 3'h0;
		end else begin
			pre_q <= mc_tick ? 3'h0 : pre_q + 3'h1;
		end
	end
	assign mc_tick = pre_q == dtsp_pkg::MC_LAST;
	assign sclk    = pre_q >= dtsp_pkg::SCLK_HIGH_FROM;

	////////////////////////////////////////////////////////////////////////////////
	// Count pins are sampled once per machine cycle for falling edges.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prev_q <= 2'h3;
		end else if (mc_tick) begin
			prev_q <= sync_q[1:0];
		end
	end

	// Count pulse: run bit, gate qualifier, then timer or counter source.
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			cnt_en[i] = run_q[i] && (!tmode_q[i].gate || sync_q[2 + i])
				&& (tmode_q[i].ct ? (mc_tick && prev_q[i] && !sync_q[i]) : mc_tick);
		end
		if (tmode_q[1].mode == dtsp_pkg::TM_SPLIT) begin
			cnt_en[1] = 1'b0;
		end
	end

	dtsp_timer u_tmr0 (
		.clk     (clk),
		.sys_rst (sys_rst),
		.mode    (tmode_q[0].mode),
		.cnt_en  (cnt_en[0]),
		.hi_en   (run_q[1] && mc_tick),
		.wr_lo   (wr_to(dtsp_pkg::ADDR_FIRST_LOW)),
		.wr_hi   (wr_to(dtsp_pkg::ADDR_FIRST_HIGH)),
		.wdata   (sfr_wdata),
		.tl_q    (tl0),
		.th_q    (th0),
		.lo_ovf  (lo_ovf[0]),
		.hi_ovf  (hi_ovf0)
	);

	dtsp_timer u_tmr1 (
		.clk     (clk),
		.sys_rst (sys_rst),
		.mode    (tmode_q[1].mode),
		.cnt_en  (cnt_en[1]),
		.hi_en   (1'b0),
		.wr_lo   (wr_to(dtsp_pkg::ADDR_SECOND_LOW)),
		.wr_hi   (wr_to(dtsp_pkg::ADDR_SECOND_HIGH)),
		.wdata   (sfr_wdata),
		.tl_q    (tl1),
		.th_q    (th1),
		.lo_ovf  (lo_ovf[1]),
		.hi_ovf  ()
	);

	// In split mode the first high byte takes over the second flag.
	assign set_ovf[0] = lo_ovf[0];
	assign set_ovf[1] = (tmode_q[0].mode == dtsp_pkg::TM_SPLIT) ? hi_ovf0 : lo_ovf[1];

	////////////////////////////////////////////////////////////////////////////////
	// Timer mode, run bits and configuration; run writes never touch counts.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tmode_q[0] <= '0;
			tmode_q[1] <= '0;
			run_q      <= 2'h0;
			tog_en_q   <= 2'h0;
			baud_dbl_q <= 1'b0;
			bit7_sel_q <= 1'b0;
		end else begin
			if (wr_to(dtsp_pkg::ADDR_TIMER_MODE)) begin
				tmode_q[1] <= sfr_wdata[7:4];
				tmode_q[0] <= sfr_wdata[3:0];
			end
			if (wr_to(dtsp_pkg::ADDR_TIMER_CTRL)) begin
				run_q <= {sfr_wdata[dtsp_pkg::CTL_SECOND_RUN], sfr_wdata[dtsp_pkg::CTL_FIRST_RUN]};
			end
			if (wr_to(dtsp_pkg::ADDR_PORT2_MODE)) begin
				tog_en_q <= {sfr_wdata[dtsp_pkg::PM_SECOND_TOG], sfr_wdata[dtsp_pkg::PM_FIRST_TOG]};
			end
			if (wr_to(dtsp_pkg::ADDR_POWER_CTRL)) begin
				baud_dbl_q <= sfr_wdata[dtsp_pkg::PC_BAUD_DBL];
				bit7_sel_q <= sfr_wdata[dtsp_pkg::PC_BIT7_SEL];
			end
		end
	end

	// Overflow flags: a hardware set wins over a software clear.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ovf_q <= 2'h0;
		end else begin
			if (set_ovf[0]) begin
				ovf_q[0] <= 1'b1;
			end else if (wr_to(dtsp_pkg::ADDR_TIMER_CTRL)) begin
				ovf_q[0] <= sfr_wdata[dtsp_pkg::CTL_FIRST_OVF];
			end
			if (set_ovf[1]) begin
				ovf_q[1] <= 1'b1;
			end else if (wr_to(dtsp_pkg::ADDR_TIMER_CTRL)) begin
				ovf_q[1] <= sfr_wdata[dtsp_pkg::CTL_SECOND_OVF];
			end
		end
	end

	// Toggle outputs sit high while disabled, so they start high when enabled.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tog_q <= 2'h3;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (!tog_en_q[i]) begin
					tog_q[i] <= 1'b1;
				end else if (set_ovf[i]) begin
					tog_q[i] <= !tog_q[i];
				end
			end
		end
	end
	assign count_pin_out = tog_q;
	assign count_pin_oe  = tog_en_q;

	////////////////////////////////////////////////////////////////////////////////
	// Sixteen-times bit tick: fixed clock in mode 2, second timer otherwise.
	// Without the doubler every second source pulse is dropped.
	assign smode   = {mode_hi_q, mode_lo_q};
	assign brg_src = (smode == dtsp_pkg::SM_FIXED9) ? 1'b1 : lo_ovf[1];
	assign tick16  = brg_src && (baud_dbl_q || half_q);
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			half_q <= 1'b0;
		end else if (brg_src) begin
			half_q <= !half_q;
		end
	end

	// Transmitter: a buffer write loads the frame; a new write restarts it.
	assign tx_len  = (smode == dtsp_pkg::SM_SHIFT) ? dtsp_pkg::SHIFT_BITS
		: (smode == dtsp_pkg::SM_UART8) ? dtsp_pkg::FRAME_LEN_8 : dtsp_pkg::FRAME_LEN_9;
	assign tx_step = (smode == dtsp_pkg::SM_SHIFT) ? mc_tick
		: (tick16 && tx_ph_q == dtsp_pkg::BIT_LAST);
	assign tx_fin  = tx_busy_q && tx_step && tx_bit_q == tx_len - 4'h1;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tx_busy_q <= 1'b0;
			tx_sh_q   <= 11'h7ff;
			tx_bit_q  <= 4'h0;
			tx_ph_q   <= 4'h0;
		end else if (wr_to(dtsp_pkg::ADDR_SERIAL_BUF)) begin
			tx_busy_q <= 1'b1;
			tx_bit_q  <= 4'h0;
			tx_ph_q   <= 4'h0;
			if (smode == dtsp_pkg::SM_SHIFT) begin
				tx_sh_q <= {3'h7, sfr_wdata};
			end else begin
				tx_sh_q <= {1'b1, (smode == dtsp_pkg::SM_UART8) ? 1'b1 : tx9_q,
					sfr_wdata, 1'b0};
			end
		end else if (tx_busy_q) begin
			if (tick16) begin
				tx_ph_q <= tx_ph_q + 4'h1;
			end
			if (tx_step) begin
				tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
				tx_bit_q <= tx_bit_q + 4'h1;
			end
			if (tx_fin) begin
				tx_busy_q <= 1'b0;
			end
		end
	end

	// Pin drivers: shift mode puts data on rxd and the shift clock on txd.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			txd     <= 1'b1;
			rxd_out <= 1'b1;
			rxd_oe  <= 1'b0;
		end else begin
			if (smode == dtsp_pkg::SM_SHIFT) begin
				txd <= (tx_busy_q || rx_shift) ? sclk : 1'b1;
			end else begin
				txd <= tx_busy_q ? tx_sh_q[0] : 1'b1;
			end
			rxd_out <= tx_sh_q[0];
			rxd_oe  <= tx_busy_q && smode == dtsp_pkg::SM_SHIFT;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Receiver runs independently of the transmitter.
	assign shift_go = smode == dtsp_pkg::SM_SHIFT && rx_en_q && !rx_done_q
		&& !rx_fin && !rx_shift;

	dtsp_rx u_rx (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.smode      (smode),
		.rx_en      (rx_en_q),
		.shift_go   (shift_go),
		.mc_tick    (mc_tick),
		.tick16     (tick16),
		.rxd_s      (sync_q[4]),
		.shift_busy (rx_shift),
		.done_q     (rx_fin),
		.sh_q       (rx_sh),
		.stop_q     (rx_stop)
	);

	// Completed bytes always overwrite the receive buffer, even if unread.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rx_buf_q <= dtsp_pkg::REG_RST;
		end else if (rx_fin) begin
			rx_buf_q <= rx_sh[7:0];
		end
	end

	// Serial control and status; hardware sets beat software clears.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{mode_hi_q, mode_lo_q, mpq_q, rx_en_q, tx9_q} <= 5'h00;
			{rx9_q, tx_done_q, rx_done_q, frame_err_q}     <= 4'h0;
		end else begin
			if (wr_to(dtsp_pkg::ADDR_SERIAL_CTRL)) begin
				mode_lo_q <= sfr_wdata[dtsp_pkg::SC_MODE_LO];
				mpq_q     <= sfr_wdata[dtsp_pkg::SC_MPQ];
				rx_en_q   <= sfr_wdata[dtsp_pkg::SC_RX_EN];
				tx9_q     <= sfr_wdata[dtsp_pkg::SC_TX9];
				if (!bit7_sel_q) begin
					mode_hi_q <= sfr_wdata[dtsp_pkg::SC_MODE_HI];
				end
			end
			if (tx_fin) begin
				tx_done_q <= 1'b1;
			end else if (wr_to(dtsp_pkg::ADDR_SERIAL_CTRL)) begin
				tx_done_q <= sfr_wdata[dtsp_pkg::SC_TX_DONE];
			end
			if (rx_fin) begin
				rx_done_q <= 1'b1;
			end else if (wr_to(dtsp_pkg::ADDR_SERIAL_CTRL)) begin
				rx_done_q <= sfr_wdata[dtsp_pkg::SC_RX_DONE];
			end
			if (rx_fin && smode != dtsp_pkg::SM_SHIFT) begin
				rx9_q <= (smode == dtsp_pkg::SM_UART8) ? rx_stop : rx_sh[8];
			end else if (wr_to(dtsp_pkg::ADDR_SERIAL_CTRL)) begin
				rx9_q <= sfr_wdata[dtsp_pkg::SC_RX9];
			end
			if (rx_fin && smode != dtsp_pkg::SM_SHIFT && !rx_stop) begin
				frame_err_q <= 1'b1;
			end else if (wr_to(dtsp_pkg::ADDR_SERIAL_CTRL) && bit7_sel_q) begin
				frame_err_q <= sfr_wdata[dtsp_pkg::SC_MODE_HI];
			end
		end
	end

	// Read data is registered; unmapped addresses read as zero.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sfr_rdata <= dtsp_pkg::REG_RST;
		end else if (sfr_rd) begin
			case (sfr_addr)
				dtsp_pkg::ADDR_TIMER_CTRL:  sfr_rdata <= {ovf_q[1], run_q[1], ovf_q[0], run_q[0], 4'h0};
				dtsp_pkg::ADDR_TIMER_MODE:  sfr_rdata <= {tmode_q[1], tmode_q[0]};
				dtsp_pkg::ADDR_FIRST_LOW:   sfr_rdata <= tl0;
				dtsp_pkg::ADDR_SECOND_LOW:  sfr_rdata <= tl1;
				dtsp_pkg::ADDR_FIRST_HIGH:  sfr_rdata <= th0;
				dtsp_pkg::ADDR_SECOND_HIGH: sfr_rdata <= th1;
				dtsp_pkg::ADDR_SERIAL_CTRL: sfr_rdata <= {bit7_sel_q ? frame_err_q : mode_hi_q,
					mode_lo_q, mpq_q, rx_en_q, tx9_q, rx9_q, tx_done_q, rx_done_q};
				dtsp_pkg::ADDR_SERIAL_BUF:  sfr_rdata <= rx_buf_q;
				dtsp_pkg::ADDR_POWER_CTRL:  sfr_rdata <= {baud_dbl_q, bit7_sel_q, 6'h00};
				dtsp_pkg::ADDR_PORT2_MODE:  sfr_rdata <= {6'h00, tog_en_q};
				default:                    sfr_rdata <= dtsp_pkg::REG_RST;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	property p_mc_period;
		mc_tick |=> (!mc_tick)[*5] ##1 mc_tick;
	endproperty
	a_mc_period: assert property (p_mc_period) else $error("machine cycle not six clocks");
	property p_ovf_set;
		set_ovf[0] |=> ovf_q[0];
	endproperty
	a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");
	property p_gate;
		cnt_en[0] |-> run_q[0] && (!tmode_q[0].gate || sync_q[2]);
	endproperty
	a_gate: assert property (p_gate) else $error("count while not enabled");
	property p_run_keeps;
		wr_to(dtsp_pkg::ADDR_TIMER_CTRL) && !cnt_en[0]
			&& !(tmode_q[0].mode == dtsp_pkg::TM_SPLIT && run_q[1] && mc_tick)
			|=> $stable(tl0) && $stable(th0);
	endproperty
	a_run_keeps: assert property (p_run_keeps) else $error("run write changed count");
	property p_reload;
		tmode_q[0].mode == dtsp_pkg::TM_RELOAD && lo_ovf[0] && !sfr_wr |=> tl0 == th0;
	endproperty
	a_reload: assert property (p_reload) else $error("reload failed");
	property p_split_halt;
		tmode_q[1].mode == dtsp_pkg::TM_SPLIT |-> !cnt_en[1];
	endproperty
	a_split_halt: assert property (p_split_halt) else $error("second timer ran in split");
	property p_toggle;
		set_ovf[0] && tog_en_q[0] |=> tog_q[0] != $past(tog_q[0]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("toggle output missed");
	property p_buf_read;
		sfr_rd && sfr_addr == dtsp_pkg::ADDR_SERIAL_BUF |=> sfr_rdata == $past(rx_buf_q);
	endproperty
	a_buf_read: assert property (p_buf_read) else $error("buffer read wrong");
	property p_start_bit;
		wr_to(dtsp_pkg::ADDR_SERIAL_BUF) && smode != dtsp_pkg::SM_SHIFT |-> ##2 !txd;
	endproperty
	a_start_bit: assert property (p_start_bit) else $error("no start bit");
	property p_rx_done;
		rx_fin |=> rx_done_q;
	endproperty
	a_rx_done: assert property (p_rx_done) else $error("receive done lost");
	property p_tx_done;
		tx_fin && !wr_to(dtsp_pkg::ADDR_SERIAL_BUF) |=> tx_done_q && !tx_busy_q;
	endproperty
	a_tx_done: assert property (p_tx_done) else $error("transmit done lost");
	property p_frame_sticky;
		frame_err_q && !wr_to(dtsp_pkg::ADDR_SERIAL_CTRL) |=> frame_err_q;
	endproperty
	a_frame_sticky: assert property (p_frame_sticky) else $error("framing error dropped");

	c_rx_async: cover property (rx_fin && smode == dtsp_pkg::SM_UART8);
	c_tx_shift: cover property (tx_fin && smode == dtsp_pkg::SM_SHIFT);
	c_split_hi: cover property (hi_ovf0);
	c_frame_err: cover property ($rose(frame_err_q));

endmodule // dtsp_top

// ===== tb/dtsp_far_end.sv
`timescale 1ns/100ps
// Far serial sender; its line rests high between frames.
module dtsp_far_end (
	input  wire logic clk,
	output logic      line
);
	initial line = 1'b1;
	// Start, nine bits LSB first, then stop; a stop of 0 is a deliberate framing fault.
	task automatic send(input logic [8:0] d, input logic stp, input int per);
		logic [10:0] f;
		f = {stp, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			line <= f[i];
			repeat (per) @(posedge clk);
		end
		line <= 1'b1;
	endtask
endmodule // dtsp_far_end

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic        clk, sys_rst, sfr_wr, sfr_rd, txd, rxd_out, rxd_oe, rxd_far, rx_pin;
	logic  [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd, b, rb;
	logic        n9, r9;
	logic [10:0] got;
	logic  [1:0] cpin, gpin, cpo, cpe, m;
	int          per;
	int          n_fail, total_checks;
	dtsp_top dtsp_top_inst (.clk(clk), .sys_rst(sys_rst), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
		.count_pin_in(cpin), .count_pin_out(cpo), .count_pin_oe(cpe), .gating_input_pin(gpin),
		.rxd_in(rx_pin), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
	dtsp_far_end dtsp_far_end_inst (.clk(clk), .line(rxd_far));
	// The device owns the shared receive pin only while it drives it.
	assign rx_pin = rxd_oe ? rxd_out : rxd_far;
	// Free-running system clock.
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Counts every compare and reports a mismatch at once.
	task automatic chk(input string nm, input logic [10:0] ex, input logic [10:0] gt);
		total_checks++;
		if (gt !== ex) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, gt);
		end
	endtask
	// A wait that ran out of its bound ends the run, since later steps would hang.
	task automatic bound(input logic ok);
		if (ok !== 1'b1) begin
			n_fail++;
			wrap_up();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge clk);
		sfr_wr <= 1'b0;
		@(posedge clk);
	endtask
	// Read data is registered, so it is taken one edge after the strobe.
	task automatic rdr(input logic [7:0] a);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge clk);
		sfr_rd <= 1'b0;
		@(posedge clk);
		rd = sfr_rdata;
	endtask
	// Expected nine-bit frame on the wire, start bit first.
	function automatic logic [10:0] frame(input logic [7:0] d, input logic t9);
		return {1'b1, t9, d, 1'b0};
	endfunction
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset, timer reload, then full-duplex frames.
	initial begin
		sys_rst = 1'b1;
		{sfr_wr, sfr_rd, sfr_addr, sfr_wdata, rd} = 26'h0;
		{cpin, gpin} = 4'hf;
		void'($urandom(93));
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		rdr(8'h98);
		chk("serial ctrl reset", 11'h000, {3'h0, rd});
		wr(8'h89, 8'h02);
		wr(8'h8a, 8'hfe);
		wr(8'h8c, 8'h10);
		wr(8'ha4, 8'h01);
		chk("toggle idle", 11'h007, {7'h0, cpe, cpo});
		wr(8'h88, 8'h10);
		for (int i = 0; i < 20 && rd[5] !== 1'b1; i++)
			rdr(8'h88);
		bound(rd[5]);
		chk("toggle flip", 11'h006, {7'h0, cpe, cpo});
		rdr(8'h8a);
		// One more tick may already have landed after the reload.
		chk("reload", 11'h010, {3'h0, rd & 8'hfe});
		// A low gate pin must freeze the count, and releasing it must resume it.
		gpin <= 2'h0;
		wr(8'h89, 8'h0a);
		rdr(8'h8a);
		b = rd;
		repeat (24) @(posedge clk);
		rdr(8'h8a);
		chk("gated", {3'h0, b}, {3'h0, rd});
		gpin <= 2'h3;
		repeat (24) @(posedge clk);
		rdr(8'h8a);
		chk("gate open", 11'h001, {10'h0, rd != b});
		// Three falling edges on the count pin carry the 13-bit counter over.
		wr(8'h89, 8'h04);
		wr(8'h8a, 8'hff);
		wr(8'h8c, 8'h10);
		repeat (3) begin
			cpin <= 2'h2;
			repeat (12) @(posedge clk);
			cpin <= 2'h3;
			repeat (12) @(posedge clk);
		end
		rdr(8'h8a);
		chk("13-bit low", 11'h0e2, {3'h0, rd});
		rdr(8'h8c);
		chk("13-bit high", 11'h011, {3'h0, rd});
		$display("timer test done");
		// Second timer reloads all ones, so it overflows every machine cycle.
		wr(8'h89, 8'h24);
		wr(8'h8b, 8'hff);
		wr(8'h8d, 8'hff);
		wr(8'h88, 8'h50);
		wr(8'h87, 8'h80);
		// Fixed-rate nine-bit, timer-rate nine-bit, then timer-rate eight-bit frames.
		for (int k = 0; k < 3; k++) begin
			m = (k == 0) ? 2'h2 : (k == 1) ? 2'h3 : 2'h1;
			per = (k == 0) ? 16 : 96;
			b = 8'($urandom);
			rb = 8'($urandom);
			{n9, r9} = 2'($urandom);
			if (k == 2)
				r9 = 1'b1;
			wr(8'h98, {m, 2'h1, n9, 3'h0});
			fork
				begin
					wr(8'h99, b);
					for (int i = 0; i < 8 && txd !== 1'b0; i++)
						@(posedge clk);
					bound(txd === 1'b0);
					repeat (per / 2) @(posedge clk);
					for (int j = 0; j < 11; j++) begin
						got[j] = txd;
						repeat (per) @(posedge clk);
					end
					chk("tx frame", frame(b, n9 || k == 2), got);
				end
				dtsp_far_end_inst.send({r9, rb}, k != 0, per);
			join
			rdr(8'h99);
			chk("rx buffer", {3'h0, rb}, {3'h0, rd});
			rdr(8'h98);
			chk("flags", {8'h0, r9, 2'h3}, {3'h0, rd & 8'h07});
		end
		// Split first timer: its high byte alone must raise the second flag.
		wr(8'h89, 8'h23);
		wr(8'h8c, 8'hfe);
		wr(8'h88, 8'h40);
		rd = 8'h00;
		for (int i = 0; i < 20 && rd[7] !== 1'b1; i++)
			rdr(8'h88);
		bound(rd[7]);
		rdr(8'h8c);
		chk("split high", 11'h000, {3'h0, rd & 8'hfe});
		// The bad first stop must still show after a good frame.
		wr(8'h87, 8'hc0);
		rdr(8'h98);
		chk("framing error", 11'h080, {3'h0, rd & 8'h80});
		$display("serial test done");
		wrap_up();
	end
endmodule // testbench
